// file: core/wtc_defines.vh
// wtc_defines.vh: constants for the waveform trigger control block
`ifndef WTC_DEFINES_VH
`define WTC_DEFINES_VH
// register map (word index in low address bits)
`define WTC_ADDR_W 4
`define WTC_REG_CTRL 4'h0
`define WTC_REG_RCOUNT 4'h1
`define WTC_REG_LEN 4'h2
`define WTC_REG_CMD 4'h3
`define WTC_REG_STATUS 4'h4
`define WTC_REG_PASSES 4'h5
// ctrl field positions
`define WTC_CTRL_RUNMODE_LO 0
`define WTC_CTRL_RUNMODE_HI 1
`define WTC_CTRL_RETRIG 2
`define WTC_CTRL_SRC_LO 3
`define WTC_CTRL_SRC_HI 4
`define WTC_CTRL_SLOPE 5
`define WTC_CTRL_SEGAUTO 6
`define WTC_CTRL_MULTISEG 7
`define WTC_CTRL_SYNC_LO 8
`define WTC_CTRL_SYNC_HI 9
`define WTC_CTRL_PBEN 10
`define WTC_CTRL_LOADED 11
`define WTC_CTRL_W 12
// run modes
`define WTC_MODE_CONT 2'h0
`define WTC_MODE_SINGLE 2'h1
`define WTC_MODE_REPEAT 2'h2
// trigger sources
`define WTC_SRC_MANUAL 2'h0
`define WTC_SRC_EXT 2'h1
`define WTC_SRC_BUS 2'h2
`define WTC_SRC_AUTO 2'h3
// sync modes
`define WTC_SYNC_NORMAL 2'h0
`define WTC_SYNC_MASTER 2'h1
`define WTC_SYNC_SLAVE 2'h2
`define WTC_SYNC_LAST 2'h3
// command bits
`define WTC_CMD_EXEC 0
`define WTC_CMD_BUSTRIG 1
// repeat count
`define WTC_RCOUNT_W 7
`define WTC_RCOUNT_MAX 7'h64
`define WTC_RCOUNT_RST 7'h0A
// waveform length
`define WTC_LEN_W 16
`define WTC_LEN_RST 16'h0400
// retrigger spacing: 10 us plus 25 symbol periods
`define WTC_CLK_MHZ 100
`define WTC_GAP_US 10
`define WTC_GAP_SYMS 25
`define WTC_GAP_CNT_W 11
// the same spacing as sized counter loads: 10 us of cycles, 25 symbol periods
`define WTC_GAP_US_CYC 11'h3E8
`define WTC_GAP_SYM_CNT 11'h019
`define WTC_DATA_W 32
`endif

// file: core/wtc_gap_timer.v
// wtc_gap_timer.v: retrigger hold-off timer in memory-clock ticks
`timescale 1ns/1ps
`include "wtc_defines.vh"
module wtc_gap_timer (
  input wire clk,
  input wire sys_rst,
  input wire start,
  input wire sym_tick,
  output wire busy
);
  // sized constants, so nothing is cut when loading the counters
  localparam [`WTC_GAP_CNT_W-1:0] US_CYC = `WTC_GAP_US_CYC;
  localparam [`WTC_GAP_CNT_W-1:0] SYM_N = `WTC_GAP_SYM_CNT;
  reg [`WTC_GAP_CNT_W-1:0] us_reg;
  reg [`WTC_GAP_CNT_W-1:0] sym_reg;
  ////////////////////////////////////////////////////////////////
  // two phases: fixed time first, then a count of symbol periods
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      us_reg <= {`WTC_GAP_CNT_W{1'b0}};
      sym_reg <= {`WTC_GAP_CNT_W{1'b0}};
    end else if (start) begin
      us_reg <= US_CYC;
      sym_reg <= SYM_N;
    end else if (us_reg != {`WTC_GAP_CNT_W{1'b0}}) begin
      us_reg <= us_reg - 1'b1;
    end else if (sym_reg != {`WTC_GAP_CNT_W{1'b0}} && sym_tick) begin
      sym_reg <= sym_reg - 1'b1;
    end
  end
  assign busy = (us_reg != {`WTC_GAP_CNT_W{1'b0}}) ||
    (sym_reg != {`WTC_GAP_CNT_W{1'b0}});
endmodule // wtc_gap_timer

// file: core/wtc_trigger_ctrl.v
// wtc_trigger_ctrl.v: trigger sequencing for the waveform playback engine
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "wtc_defines.vh"
module wtc_trigger_ctrl (
  input wire clk,
  input wire sys_rst,
  input wire [`WTC_ADDR_W-1:0] reg_addr,
  input wire [`WTC_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`WTC_DATA_W-1:0] reg_rdata,
  input wire rear_trigger_input,
  input wire trigger_key,
  input wire segment_trigger,
  input wire sym_tick,
  output reg play_restart,
  output reg play_active,
  output reg [`WTC_LEN_W-1:0] play_addr,
  output reg segment_advance
);
  // sequencer states: idle until a first start, run, done after the last pass
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_DONE = 2'h2;
  // software-visible settings
  reg [`WTC_CTRL_W-1:0] ctrl_reg;
  reg [`WTC_RCOUNT_W-1:0] rcount_reg;
  reg [`WTC_LEN_W-1:0] len_reg;
  // sequencer state and the values it moves to
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [`WTC_RCOUNT_W-1:0] pass_reg;
  reg [`WTC_RCOUNT_W-1:0] pass_next;
  reg [`WTC_LEN_W-1:0] addr_next;
  reg restart_next;
  // pin chains: two stages to settle, a third only to find edges
  reg rear_trigger_input_s1_reg;
  reg rear_trigger_input_s2_reg;
  reg rear_trigger_input_s3_reg;
  reg key_s1_reg;
  reg key_s2_reg;
  reg key_s3_reg;
  reg seg_s1_reg;
  reg seg_s2_reg;
  reg seg_s3_reg;
  reg pben_d_reg;
  // one-cycle pulses made by command writes
  reg exec_pulse_reg;
  reg bus_pulse_reg;
  // decoded fields and trigger qualifiers
  wire [1:0] run_mode;
  wire [1:0] eff_mode;
  wire [1:0] src;
  wire [1:0] sync;
  wire retrig_on;
  wire is_slave;
  wire pb_en;
  wire loaded;
  wire ext_edge;
  wire key_rise;
  wire raw_rear_trigger_input;
  wire acc_rear_trigger_input;
  wire gap_busy;
  wire last_word;
  wire pben_rise;

  ////////////////////////////////////////////////////////////////
  // clamp a written repeat count into 1..100
  // zero would also end after the first pass; it is stored as one
  function [`WTC_RCOUNT_W-1:0] wtc_clamp;
    input [`WTC_DATA_W-1:0] v;
    begin
      if (v > `WTC_RCOUNT_MAX)
        wtc_clamp = `WTC_RCOUNT_MAX;
      else if (v == {`WTC_DATA_W{1'b0}})
        wtc_clamp = {{(`WTC_RCOUNT_W-1){1'b0}}, 1'b1};
      else
        wtc_clamp = v[`WTC_RCOUNT_W-1:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // field decode
  assign run_mode = ctrl_reg[`WTC_CTRL_RUNMODE_HI:`WTC_CTRL_RUNMODE_LO];
  assign src = ctrl_reg[`WTC_CTRL_SRC_HI:`WTC_CTRL_SRC_LO];
  assign sync = ctrl_reg[`WTC_CTRL_SYNC_HI:`WTC_CTRL_SYNC_LO];
  assign pb_en = ctrl_reg[`WTC_CTRL_PBEN];
  assign loaded = ctrl_reg[`WTC_CTRL_LOADED];
  // repeat mode only when segment source is automatic
  assign eff_mode = (run_mode == `WTC_MODE_REPEAT && !ctrl_reg[`WTC_CTRL_SEGAUTO]) ?
    `WTC_MODE_CONT : run_mode;
  assign retrig_on = ctrl_reg[`WTC_CTRL_RETRIG] | ctrl_reg[`WTC_CTRL_MULTISEG];
  assign is_slave = (sync == `WTC_SYNC_SLAVE) || (sync == `WTC_SYNC_LAST);

  ////////////////////////////////////////////////////////////////
  // pin synchronisers; the second and third stages feed edge logic
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rear_trigger_input_s1_reg <= 1'b0;
      rear_trigger_input_s2_reg <= 1'b0;
      rear_trigger_input_s3_reg <= 1'b0;
      key_s1_reg <= 1'b0;
      key_s2_reg <= 1'b0;
      key_s3_reg <= 1'b0;
      seg_s1_reg <= 1'b0;
      seg_s2_reg <= 1'b0;
      seg_s3_reg <= 1'b0;
    end else begin
      rear_trigger_input_s1_reg <= rear_trigger_input;
      rear_trigger_input_s2_reg <= rear_trigger_input_s1_reg;
      rear_trigger_input_s3_reg <= rear_trigger_input_s2_reg;
      key_s1_reg <= trigger_key;
      key_s2_reg <= key_s1_reg;
      key_s3_reg <= key_s2_reg;
      seg_s1_reg <= segment_trigger;
      seg_s2_reg <= seg_s1_reg;
      seg_s3_reg <= seg_s2_reg;
    end
  end

  // slope bit high selects the falling edge
  assign ext_edge = ctrl_reg[`WTC_CTRL_SLOPE] ? (rear_trigger_input_s3_reg & ~rear_trigger_input_s2_reg) :
    (~rear_trigger_input_s3_reg & rear_trigger_input_s2_reg);
  assign key_rise = key_s2_reg & ~key_s3_reg;

  ////////////////////////////////////////////////////////////////
  // source select; slaves see only the rear input
  assign raw_rear_trigger_input = is_slave ? (src == `WTC_SRC_EXT && ext_edge) :
    (src == `WTC_SRC_MANUAL) ? (exec_pulse_reg | key_rise) :
    (src == `WTC_SRC_EXT) ? ext_edge :
    (src == `WTC_SRC_BUS) ? bus_pulse_reg :
    1'b0;

  // the hold-off only gates retriggers while running; it is the source's
  // job to respect the spacing, extra events are dropped here
  assign acc_rear_trigger_input = raw_rear_trigger_input && pb_en && loaded &&
    !(state_reg == ST_RUN && gap_busy);

  // hold-off timer restarts on every accepted trigger
  wtc_gap_timer u_gap (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(acc_rear_trigger_input),
    .sym_tick(sym_tick),
    .busy(gap_busy)
  );

  ////////////////////////////////////////////////////////////////
  // register writes and one-cycle command pulses
  // a repeat count above the limit saturates instead of wrapping
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= {`WTC_CTRL_W{1'b0}};
      rcount_reg <= `WTC_RCOUNT_RST;
      len_reg <= `WTC_LEN_RST;
      exec_pulse_reg <= 1'b0;
      bus_pulse_reg <= 1'b0;
    end else begin
      exec_pulse_reg <= 1'b0;
      bus_pulse_reg <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          `WTC_REG_CTRL: ctrl_reg <= reg_wdata[`WTC_CTRL_W-1:0];
          `WTC_REG_RCOUNT: rcount_reg <= wtc_clamp(reg_wdata);
          `WTC_REG_LEN: len_reg <= reg_wdata[`WTC_LEN_W-1:0];
          `WTC_REG_CMD: begin
            exec_pulse_reg <= reg_wdata[`WTC_CMD_EXEC];
            bus_pulse_reg <= reg_wdata[`WTC_CMD_BUSTRIG];
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // read port: data valid the cycle after the strobe, zero when unmapped
  // status is the registered running flag, in step with the sequencer state
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= {`WTC_DATA_W{1'b0}};
    end else if (reg_rd) begin
      case (reg_addr)
        `WTC_REG_CTRL: reg_rdata <= {{(`WTC_DATA_W-`WTC_CTRL_W){1'b0}}, ctrl_reg};
        `WTC_REG_RCOUNT: reg_rdata <= {{(`WTC_DATA_W-`WTC_RCOUNT_W){1'b0}}, rcount_reg};
        `WTC_REG_LEN: reg_rdata <= {{(`WTC_DATA_W-`WTC_LEN_W){1'b0}}, len_reg};
        `WTC_REG_STATUS: reg_rdata <= {{(`WTC_DATA_W-1){1'b0}}, play_active};
        `WTC_REG_PASSES: reg_rdata <= {{(`WTC_DATA_W-`WTC_RCOUNT_W){1'b0}}, pass_reg};
        default: reg_rdata <= {`WTC_DATA_W{1'b0}};
      endcase
    end else begin
      reg_rdata <= {`WTC_DATA_W{1'b0}};
    end
  end

  ////////////////////////////////////////////////////////////////
  // playback sequencer
  // a length of zero wraps, so the pass runs over the whole address range
  assign last_word = (play_addr == len_reg - 1'b1);
  // turning playback back on is a restart only if the sequencer enters run in that cycle
  assign pben_rise = pb_en & ~pben_d_reg;

  always @* begin
    state_next = state_reg;
    pass_next = pass_reg;
    addr_next = play_addr;
    restart_next = 1'b0;
    if (!pb_en || !loaded) begin
      // switching playback off parks the engine; on again rearms it
      state_next = ST_IDLE;
      addr_next = {`WTC_LEN_W{1'b0}};
      pass_next = {`WTC_RCOUNT_W{1'b0}};
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // auto source needs no event; slaves never start by themselves
          if (src == `WTC_SRC_AUTO && !is_slave) begin
            state_next = ST_RUN;
            restart_next = 1'b1;
            addr_next = {`WTC_LEN_W{1'b0}};
            pass_next = {`WTC_RCOUNT_W{1'b0}};
          end else if (acc_rear_trigger_input) begin
            state_next = ST_RUN;
            restart_next = 1'b1;
            addr_next = {`WTC_LEN_W{1'b0}};
            pass_next = {`WTC_RCOUNT_W{1'b0}};
          end
        end
        ST_RUN: begin
          // a retrigger beats the end of a pass, so it is never lost
          if (acc_rear_trigger_input && retrig_on) begin
            restart_next = 1'b1;
            addr_next = {`WTC_LEN_W{1'b0}};
            pass_next = {`WTC_RCOUNT_W{1'b0}};
          end else if (last_word) begin
            addr_next = {`WTC_LEN_W{1'b0}};
            if (eff_mode == `WTC_MODE_SINGLE) begin
              state_next = ST_DONE;
            end else if (eff_mode == `WTC_MODE_REPEAT) begin
              pass_next = pass_reg + 1'b1;
              if (pass_reg + 1'b1 >= rcount_reg)
                state_next = ST_DONE;
            end else begin
              addr_next = {`WTC_LEN_W{1'b0}};
            end
          end else begin
            addr_next = play_addr + 1'b1;
          end
        end
        ST_DONE: begin
          // with retrigger and multi-segment both off only single mode restarts here; repeat mode
          // then needs the playback enable switched off and on
          if (acc_rear_trigger_input && (retrig_on || eff_mode == `WTC_MODE_SINGLE)) begin
            state_next = ST_RUN;
            restart_next = 1'b1;
            addr_next = {`WTC_LEN_W{1'b0}};
            pass_next = {`WTC_RCOUNT_W{1'b0}};
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  // outputs follow the next-state values so status, address and restart
  // line up in the same cycle
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      pass_reg <= {`WTC_RCOUNT_W{1'b0}};
      play_addr <= {`WTC_LEN_W{1'b0}};
      play_restart <= 1'b0;
      play_active <= 1'b0;
      pben_d_reg <= 1'b0;
      segment_advance <= 1'b0;
    end else begin
      state_reg <= state_next;
      pass_reg <= pass_next;
      play_addr <= addr_next;
      play_restart <= restart_next | (pben_rise & (state_next == ST_RUN));
      play_active <= (state_next == ST_RUN);
      pben_d_reg <= pb_en;
      // segment stepping follows only the segment trigger
      segment_advance <= ctrl_reg[`WTC_CTRL_MULTISEG] && state_reg == ST_RUN &&
        seg_s2_reg && !seg_s3_reg;
    end
  end
endmodule // wtc_trigger_ctrl

// file: tb/waveform_trigger_control_tb_top.sv
// self-checking bench for the waveform trigger control block
`timescale 1ns/1ps
`include "wtc_defines.vh"
module waveform_trigger_control_tb_top;
  reg clk = 1'h0;
  reg sys_rst = 1'h1;
  reg [3:0] reg_addr = 4'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'h0;
  reg reg_rd = 1'h0;
  reg trigger_key = 1'h0;
  reg segment_trigger = 1'h0;
  reg sym_tick = 1'h0;
  reg lvl = 1'h0;
  wire [31:0] reg_rdata;
  wire rear_pin;
  wire play_restart;
  wire play_active;
  wire [15:0] play_addr;
  wire segment_advance;
  int err_total = 0;
  int checked = 0;
  //////////////////////////////////////////////////////////////////////////////
  wtc_trigger_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rear_trigger_input(rear_pin), .trigger_key(trigger_key),
    .segment_trigger(segment_trigger), .sym_tick(sym_tick), .play_restart(play_restart),
    .play_active(play_active), .play_addr(play_addr), .segment_advance(segment_advance));
  wtc_rear_trigger_input_src src (.clk(clk), .lvl(lvl), .pin(rear_pin));
  initial begin
    forever #5 clk = ~clk;
  end
  // a tick every second cycle keeps the retrigger gap short
  always @(posedge clk) sym_tick <= ~sym_tick;
  //////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
    // one idle edge, so a following write never sets the strobe twice in a step
    @(posedge clk);
  endtask
  // read data is taken at the edge that closes its only valid cycle
  task rchk(input [3:0] a, input [31:0] e, input string nm);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(posedge clk);
    chk(nm, reg_rdata, e);
  endtask
  task wait_rs(input int n, input bit want, input string nm);
    int i;
    for (i = 0; i < n && play_restart !== 1'h1; i++) @(posedge clk);
    chk(nm, 32'(play_restart === 1'h1), 32'(want));
    if (want && play_restart !== 1'h1)
      conclude;
  endtask
  task run_len(input int n, input int lim, input string nm);
    int c;
    for (c = 0; c < lim && play_active === 1'h1; c++) @(posedge clk);
    chk(nm, c, n);
    if (c == lim && n != lim)
      conclude;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task t_regs;
    rchk(`WTC_REG_CTRL, 32'h0, "ctrl");
    rchk(`WTC_REG_RCOUNT, 32'hA, "rcount");
    rchk(`WTC_REG_LEN, 32'h400, "len");
    rchk(4'hF, 32'h0, "unmapped");
    wr(`WTC_REG_RCOUNT, 32'hC8);
    rchk(`WTC_REG_RCOUNT, 32'h64, "rcount max");
    wr(`WTC_REG_RCOUNT, 32'h0);
    rchk(`WTC_REG_RCOUNT, 32'h1, "rcount min");
  endtask
  // repeat, retrigger, manual source: three passes of four words
  task t_manual;
    wr(`WTC_REG_LEN, 32'h4);
    wr(`WTC_REG_RCOUNT, 32'h3);
    wr(`WTC_REG_CTRL, 32'hC46);
    wr(`WTC_REG_CMD, 32'h1);
    wait_rs(5, 1, "exec");
    run_len(12, 5000, "passes");
    rchk(`WTC_REG_STATUS, 32'h0, "stopped");
    rchk(`WTC_REG_PASSES, 32'h3, "passes done");
    wr(`WTC_REG_CTRL, 32'hD46);
    trigger_key <= 1'h1;
    wait_rs(10, 1, "key");
    trigger_key <= 1'h0;
    run_len(12, 5000, "resume");
  endtask
  // second round has retrigger off but a multi-segment waveform loaded
  task t_retrig;
    int k;
    wr(`WTC_REG_LEN, 32'h2BC);
    wr(`WTC_REG_RCOUNT, 32'h2);
    for (k = 0; k < 2; k++) begin
      wr(`WTC_REG_CTRL, k ? 32'hCC2 : 32'hC46);
      wr(`WTC_REG_CMD, 32'h1);
      wait_rs(5, 1, "first");
      repeat (20) @(posedge clk);
      rchk(`WTC_REG_STATUS, 32'h1, "running");
      wr(`WTC_REG_CMD, 32'h1);
      wait_rs(10, 0, "early");
      repeat (1200) @(posedge clk);
      wr(`WTC_REG_CMD, 32'h1);
      wait_rs(5, 1, "retrig");
      chk("home", 32'(play_addr), 32'h0);
      run_len(1400, 5000, "rearm");
    end
  endtask
  // single mode: bus source, then slave and last-slave sync, then both pin edges
  task t_src;
    wr(`WTC_REG_LEN, 32'h8);
    wr(`WTC_REG_CTRL, 32'hC51);
    wr(`WTC_REG_CMD, 32'h2);
    wait_rs(5, 1, "bus");
    wr(`WTC_REG_CTRL, 32'hE51);
    repeat (10) @(posedge clk);
    wr(`WTC_REG_CMD, 32'h3);
    wait_rs(20, 0, "slave bus");
    wr(`WTC_REG_CTRL, 32'hF49);
    lvl <= 1'h1;
    wait_rs(10, 1, "slave rise");
    repeat (10) @(posedge clk);
    wr(`WTC_REG_CTRL, 32'hC69);
    lvl <= 1'h0;
    wait_rs(1300, 1, "fall");
    repeat (10) @(posedge clk);
    lvl <= 1'h1;
    wait_rs(1300, 0, "rise ignored");
  endtask
  // auto source; last word drops segment auto so repeat acts continuous
  task t_auto;
    wr(`WTC_REG_LEN, 32'h4);
    wr(`WTC_REG_RCOUNT, 32'h1);
    wr(`WTC_REG_CTRL, 32'h85A);
    wr(`WTC_REG_CTRL, 32'hC5A);
    wait_rs(6, 1, "auto start");
    run_len(4, 5000, "auto pass");
    wr(`WTC_REG_CMD, 32'h1);
    wait_rs(20, 0, "auto ignores");
    wr(`WTC_REG_CTRL, 32'h89A);
    wr(`WTC_REG_CTRL, 32'hC9A);
    wait_rs(6, 1, "enable cycle");
    run_len(50, 50, "continuous");
  endtask
  task t_seg;
    int i;
    bit r;
    r = 0;
    segment_trigger <= 1'h1;
    for (i = 0; i < 8 && segment_advance !== 1'h1; i++) begin
      @(posedge clk);
      r = r | (play_restart === 1'h1);
    end
    segment_trigger <= 1'h0;
    chk("seg advance", 32'(segment_advance === 1'h1), 32'h1);
    chk("seg restart", 32'(r), 32'h0);
    // playback off while running must park the engine
    wr(`WTC_REG_CTRL, 32'h89A);
    repeat (2) @(posedge clk);
    chk("pb off", 32'(play_active === 1'h1), 32'h0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task conclude;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    t_regs;
    t_manual;
    t_retrig;
    t_src;
    t_auto;
    t_seg;
    conclude;
  end
endmodule // waveform_trigger_control_tb_top

// file: tb/wtc_ctrl_props.sv
// assertion checker for the waveform trigger control block
`timescale 1ns/1ps
`include "wtc_defines.vh"
module wtc_ctrl_chk (
  input wire clk,
  input wire sys_rst,
  input wire [`WTC_ADDR_W-1:0] reg_addr,
  input wire [`WTC_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [`WTC_DATA_W-1:0] reg_rdata,
  input wire play_restart,
  input wire play_active,
  input wire [`WTC_LEN_W-1:0] play_addr,
  input wire segment_advance
);
  reg [`WTC_CTRL_W-1:0] ctrl_reg;
  wire cmd_wr = reg_wr && reg_addr == `WTC_REG_CMD;
  wire idle_ok = ctrl_reg[11:10] == 2'h3 && !play_active;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  //////////////////////////////////////////////////////////////////////////////
  // shadow of the control word, so source and sync mode are known here
  always @(posedge clk or posedge sys_rst)
    if (sys_rst)
      ctrl_reg <= 12'h0;
    else if (reg_wr && reg_addr == `WTC_REG_CTRL)
      ctrl_reg <= reg_wdata[11:0];
  //////////////////////////////////////////////////////////////////////////////
  AST_RESTART_HOME: assert property (play_restart |-> play_active && play_addr == 16'h0)
    else $error("restart not at address zero");
  AST_RESTART_ONE: assert property (play_restart |=> !play_restart)
    else $error("restart pulse too long");
  AST_ADDR_STEP: assert property (play_active && $past(play_active) && !play_restart |->
    play_addr == $past(play_addr) + 16'h1 || play_addr == 16'h0)
    else $error("playback address skipped");
  AST_SEG_ONE: assert property (segment_advance |=> !segment_advance)
    else $error("segment pulse too long");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  AST_STATUS: assert property ($past(reg_rd) && $past(reg_addr) == `WTC_REG_STATUS |->
    reg_rdata[0] == $past(play_active))
    else $error("status disagrees with running");
  AST_RC_RANGE: assert property ($past(reg_rd) && $past(reg_addr) == `WTC_REG_RCOUNT |->
    reg_rdata >= 32'h1 && reg_rdata <= 32'h64)
    else $error("repeat count out of range");
  AST_MAN_EXEC: assert property (cmd_wr && reg_wdata[0] && ctrl_reg[4:3] == 2'h0
    && !ctrl_reg[9] && idle_ok && (ctrl_reg[2] || ctrl_reg[7] || ctrl_reg[1:0] != 2'h2)
    |-> ##2 play_restart)
    else $error("execute did not start output");
  AST_SLAVE_REFUSE: assert property (cmd_wr && reg_wdata[1:0] != 2'h0 && ctrl_reg[9]
    && idle_ok |=> !play_restart [*4])
    else $error("slave took a non-external trigger");
  AST_PB_OFF: assert property (!ctrl_reg[10] && !$past(ctrl_reg[10])
    && !$past(ctrl_reg[10], 2) |-> !play_active)
    else $error("running with playback disabled");
endmodule // wtc_ctrl_chk

bind wtc_trigger_ctrl wtc_ctrl_chk u_chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .play_restart(play_restart), .play_active(play_active), .play_addr(play_addr),
  .segment_advance(segment_advance));

// file: tb/wtc_rear_trigger_input_src.sv
// external trigger source model driving the rear trigger pin
`timescale 1ns/1ps
module wtc_rear_trigger_input_src #(
  parameter int GAP = 1200
) (
  input wire clk,
  input wire lvl,
  output reg pin = 1'h0
);
  int since = GAP;
  // an edge waits until the spacing since the last one has run out;
  // gap covers 1000 cycles plus 25 ticks at one tick per two cycles
  always @(posedge clk) begin
    if (since < GAP)
      since <= since + 1;
    if (lvl != pin && since >= GAP) begin
      pin <= lvl;
      since <= 0;
    end
  end
endmodule // wtc_rear_trigger_input_src
